// File: hdl/vsb_pkg.sv
// Purpose: shared constants and types for the virtual serial bridge link
// Assumes: one clock mclk_i at 250 MHz on both ends
// Notes:   flow-control lines are active high on the link carrier
package vsb_pkg;

  // ------------------------------------------------------------------
  // clock and baud figures
  // ------------------------------------------------------------------
  localparam logic [31:0] CLK_HZ   = 32'h0EE6_B280; // 250 MHz
  localparam logic [19:0] BAUD_DEF = 20'h1_C200;    // 115200 bit/s
  localparam logic [19:0] BAUD_MIN = 20'h0_2580;    // 9600 bit/s
  localparam logic [19:0] BAUD_MAX = 20'hE_1000;    // 921600 bit/s
  localparam logic [15:0] DIV_DEF  = 16'(CLK_HZ / 32'(BAUD_DEF));
  localparam logic [15:0] DIV_ONE  = 16'h0001;

  // ------------------------------------------------------------------
  // character framing
  // ------------------------------------------------------------------
  localparam logic [2:0]  BIT_LAST  = 3'h7;       // 8 data bits
  localparam logic [2:0]  BIT_FIRST = 3'h0;
  localparam logic        LINE_IDLE = 1'b1;       // mark level
  localparam logic        LINE_STRT = 1'b0;       // start bit level
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [2:0]  SYNC_RST  = 3'h1;       // {enable, rts, line idle}

  // handshake setting: bit 0 drives clear-to-send, bit 1 honours rts
  typedef enum logic [1:0] {
    HS_DISABLED = 2'b00,
    HS_RTS      = 2'b01,
    HS_CTS      = 2'b10,
    HS_RTSCTS   = 2'b11
  } vsb_hs_type;

  // serial shifter states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b11,
    ST_STOP  = 2'b10
  } vsb_st_type;

endpackage

// File: hdl/vsb_link_if.sv
// Purpose: carrier joining the bridge end and the target end
// Assumes: both ends clocked by the same mclk_i
// Notes:   undriven clear-to-send line floats to its pulled-up level
`timescale 1ns/1ns
interface vsb_link_if;

  // ------------------------------------------------------------------
  // link wires
  // ------------------------------------------------------------------
  logic tgt_tx;     // serial data target to bridge
  logic tgt_rx;     // serial data bridge to target
  logic cts_drv;    // clear-to-send level from the bridge
  logic cts_oe;     // bridge drives clear-to-send
  logic rts;        // request-to-send from the target
  logic en;         // pass-through enable
  logic cts;        // resolved clear-to-send wire

  // pull-up stands in for the floating line
  assign cts = cts_oe ? cts_drv : 1'b1;

  modport bridge (input tgt_tx, rts, en, output tgt_rx, cts_drv, cts_oe);
  modport target (input tgt_rx, cts, output tgt_tx, rts, en);

endinterface // vsb_link_if

// File: hdl/vsb_target.sv
// Purpose: target-side serial port with optional hardware handshake
// Assumes: cfg_div_i is clock cycles per bit, held steady while busy
// Notes:   received bytes leave as a one-cycle pulse, no buffering
`timescale 1ns/1ns
module vsb_target
  import vsb_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  vsb_link_if.target       link,
  input  wire logic [15:0] cfg_div_i,
  input  wire logic        hw_hs_i,
  input  wire logic        en_i,
  input  wire logic        rx_ready_i,
  input  wire logic        tx_valid_i,
  input  wire logic [7:0]  tx_data_i,
  output logic             tx_ready_o,
  output logic             rx_valid_o,
  output logic [7:0]       rx_data_o
);
  import vsb_pkg::*;

  logic [1:0]  s1_q, s2_q;        // {cts, rx line}
  vsb_st_type  tx_st_q, rx_st_q;
  logic [15:0] tx_cnt_q, rx_cnt_q;
  logic [2:0]  tx_bit_q, rx_bit_q;
  logic [7:0]  tx_sh_q, rx_sh_q;
  logic        tx_line_q, rts_q, en_q;
  logic        tx_tick, rx_tick, rx_half;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s1_q <= 2'b11;
      s2_q <= 2'b11;
    end else begin
      s1_q <= {link.cts, link.tgt_rx};
      s2_q <= s1_q;
    end
  end

  // own outputs registered so pins never glitch
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rts_q <= 1'b0;
      en_q  <= 1'b0;
    end else begin
      rts_q <= rx_ready_i;  // RULE8 RULE14
      en_q  <= en_i;
    end
  end
  assign link.rts    = rts_q;
  assign link.en     = en_q;
  assign link.tgt_tx = tx_line_q;  // RULE11

  // ------------------------------------------------------------------
  // transmitter: pauses while clear-to-send is low
  // ------------------------------------------------------------------
  assign tx_tick    = (tx_cnt_q == cfg_div_i - DIV_ONE);
  assign tx_ready_o = (tx_st_q == ST_IDLE) && (!hw_hs_i || s2_q[1]);  // RULE10

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      tx_st_q   <= ST_IDLE;
      tx_cnt_q  <= '0;
      tx_bit_q  <= BIT_FIRST;
      tx_sh_q   <= BYTE_ZERO;
      tx_line_q <= LINE_IDLE;
    end else begin
      tx_cnt_q <= (tx_st_q == ST_IDLE || tx_tick) ? '0 : tx_cnt_q + DIV_ONE;
      case (tx_st_q)
        ST_IDLE: if (tx_valid_i && tx_ready_o) begin
          tx_sh_q   <= tx_data_i;
          tx_line_q <= LINE_STRT;  // RULE15
          tx_st_q   <= ST_START;
        end
        ST_START: if (tx_tick) begin
          tx_line_q <= tx_sh_q[0];
          tx_sh_q   <= tx_sh_q >> 1;
          tx_bit_q  <= BIT_FIRST;
          tx_st_q   <= ST_DATA;
        end
        ST_DATA: if (tx_tick) begin
          if (tx_bit_q == BIT_LAST) begin
            tx_line_q <= LINE_IDLE;  // RULE15
            tx_st_q   <= ST_STOP;
          end else begin
            tx_line_q <= tx_sh_q[0];
            tx_sh_q   <= tx_sh_q >> 1;
            tx_bit_q  <= tx_bit_q + 3'h1;
          end
        end
        default: if (tx_tick) tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // receiver: mid-bit sampling, stop bit must be high
  // ------------------------------------------------------------------
  assign rx_tick = (rx_cnt_q == cfg_div_i - DIV_ONE);
  assign rx_half = (rx_cnt_q == (cfg_div_i >> 1));

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rx_st_q    <= ST_IDLE;
      rx_cnt_q   <= '0;
      rx_bit_q   <= BIT_FIRST;
      rx_sh_q    <= BYTE_ZERO;
      rx_valid_o <= 1'b0;
      rx_data_o  <= BYTE_ZERO;
    end else begin
      rx_valid_o <= 1'b0;
      rx_cnt_q   <= rx_cnt_q + DIV_ONE;
      case (rx_st_q)
        ST_IDLE: begin
          rx_cnt_q <= '0;
          if (s2_q[0] == LINE_STRT) rx_st_q <= ST_START;
        end
        ST_START: if (rx_half) begin
          rx_cnt_q <= '0;
          rx_bit_q <= BIT_FIRST;
          rx_st_q  <= (s2_q[0] == LINE_STRT) ? ST_DATA : ST_IDLE;
        end
        ST_DATA: if (rx_tick) begin
          rx_cnt_q <= '0;
          rx_sh_q  <= {s2_q[0], rx_sh_q[7:1]};  // RULE15
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == BIT_LAST) rx_st_q <= ST_STOP;
        end
        default: if (rx_tick) begin
          rx_st_q    <= ST_IDLE;
          rx_valid_o <= (s2_q[0] == LINE_IDLE);
          rx_data_o  <= rx_sh_q;
        end
      endcase
    end
  end

endmodule // vsb_target

// File: hdl/vsb_bridge.sv
// Purpose: board-controller end of the virtual serial bridge
// Assumes: host paths present byte streams with valid and ready
// Notes:   socket path wins over usb; receive buffer depth is a parameter
`timescale 1ns/1ns

// Behaviour
// RULE1: reset gives 115200 8N1, no handshake
// RULE2: baud settable from 9600 to 921600
// RULE3: handshake setting gates each line separately
// RULE4: drive clear-to-send low when buffer full
// RULE5: clear-to-send undriven in disabled/cts settings
// RULE6: start characters only while rts asserted
// RULE7: never cut short a character in flight
// RULE8: target takes one more character after rts drop
// RULE9: ignore rts in disabled/rts settings
// RULE10: target transmitter pauses while clear-to-send low
// RULE11: target tx to bridge, bridge to target rx
// RULE12: data passes only while enable asserted
// RULE13: socket connected blocks the usb path
// RULE14: target sets up rts before cts modes
// RULE15: low start, lsb first, high stop, idle high
module vsb_bridge
  import vsb_pkg::*;
#(
  parameter int unsigned RX_DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  vsb_link_if.bridge            link,
  input  wire logic             cfg_wr_i,
  input  wire logic [19:0]      cfg_baud_i,
  input  wire vsb_pkg::vsb_hs_type cfg_hs_i,
  output logic [15:0]           cfg_div_o,
  output vsb_pkg::vsb_hs_type   cfg_hs_o,
  input  wire logic             sock_conn_i,
  input  wire logic             usb_tx_valid_i,
  input  wire logic [7:0]       usb_tx_data_i,
  output logic                  usb_tx_ready_o,
  input  wire logic             sock_tx_valid_i,
  input  wire logic [7:0]       sock_tx_data_i,
  output logic                  sock_tx_ready_o,
  output logic                  usb_rx_valid_o,
  output logic [7:0]            usb_rx_data_o,
  input  wire logic             usb_rx_ready_i,
  output logic                  sock_rx_valid_o,
  output logic [7:0]            sock_rx_data_o,
  input  wire logic             sock_rx_ready_i
);
  import vsb_pkg::*;

  localparam int unsigned PW = $clog2(RX_DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW+1)'(RX_DEPTH);
  localparam logic [PW:0] CNT_ROOM = (PW+1)'(RX_DEPTH - 1);

  logic [2:0]  s1_q, s2_q;        // {enable, rts, target tx line}
  logic        en_s, rts_s, line_s;
  logic [19:0] baud_c;
  logic [15:0] div_q;
  vsb_hs_type  hs_q;
  logic        hs_drive, hs_honour;
  vsb_st_type  tx_st_q, rx_st_q;
  logic [15:0] tx_cnt_q, rx_cnt_q;
  logic [2:0]  tx_bit_q, rx_bit_q;
  logic [7:0]  tx_sh_q, rx_sh_q;
  logic        tx_line_q, tx_tick, tx_allow, tx_ready, host_valid;
  logic [7:0]  host_data;
  logic        rx_tick, rx_half, rx_done;
  logic [7:0]  mem_q [RX_DEPTH];
  logic [PW-1:0] wr_q, rd_q;
  logic [PW:0] cnt_q;
  logic        push, pop, out_valid, out_ready;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end else begin
      s1_q <= {link.en, link.rts, link.tgt_tx};  // RULE11
      s2_q <= s1_q;
    end
  end
  assign {en_s, rts_s, line_s} = s2_q;

  // ------------------------------------------------------------------
  // configuration: baud clamped into range, divider worked out once
  // ------------------------------------------------------------------
  always_comb begin
    baud_c = cfg_baud_i;
    if (cfg_baud_i < BAUD_MIN) baud_c = BAUD_MIN;  // RULE2
    else if (cfg_baud_i > BAUD_MAX) baud_c = BAUD_MAX;  // RULE2
  end

  // a change mid-character skews that character; software should idle first
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      div_q <= DIV_DEF;  // RULE1
      hs_q  <= HS_DISABLED;  // RULE1
    end else if (cfg_wr_i) begin
      div_q <= 16'(CLK_HZ / 32'(baud_c));  // RULE2
      hs_q  <= cfg_hs_i;  // RULE3
    end
  end
  assign cfg_div_o = div_q;
  assign cfg_hs_o  = hs_q;
  assign hs_drive  = hs_q[0];  // RULE3
  assign hs_honour = hs_q[1];  // RULE3

  // ------------------------------------------------------------------
  // host path selection
  // ------------------------------------------------------------------
  assign host_valid      = sock_conn_i ? sock_tx_valid_i : usb_tx_valid_i;  // RULE13
  assign host_data       = sock_conn_i ? sock_tx_data_i : usb_tx_data_i;
  assign usb_tx_ready_o  = tx_ready && !sock_conn_i;  // RULE13
  assign sock_tx_ready_o = tx_ready && sock_conn_i;
  assign out_ready       = sock_conn_i ? sock_rx_ready_i : usb_rx_ready_i;
  assign usb_rx_valid_o  = out_valid && !sock_conn_i;  // RULE13
  assign sock_rx_valid_o = out_valid && sock_conn_i;
  assign usb_rx_data_o   = mem_q[rd_q];
  assign sock_rx_data_o  = mem_q[rd_q];

  // ------------------------------------------------------------------
  // transmitter toward the target
  // ------------------------------------------------------------------
  assign tx_allow = en_s && (!hs_honour || rts_s);  // RULE6 RULE9 RULE12
  assign tx_ready = (tx_st_q == ST_IDLE) && tx_allow;
  assign tx_tick  = (tx_cnt_q == div_q - DIV_ONE);
  assign link.tgt_rx = tx_line_q;  // RULE11

  // rts is only looked at in idle, so a started character always completes
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      tx_st_q   <= ST_IDLE;
      tx_cnt_q  <= '0;
      tx_bit_q  <= BIT_FIRST;
      tx_sh_q   <= BYTE_ZERO;
      tx_line_q <= LINE_IDLE;
    end else begin
      tx_cnt_q <= (tx_st_q == ST_IDLE || tx_tick) ? '0 : tx_cnt_q + DIV_ONE;
      case (tx_st_q)
        ST_IDLE: if (host_valid && tx_ready) begin
          tx_sh_q   <= host_data;
          tx_line_q <= LINE_STRT;  // RULE15
          tx_st_q   <= ST_START;
        end
        ST_START: if (tx_tick) begin  // RULE7
          tx_line_q <= tx_sh_q[0];
          tx_sh_q   <= tx_sh_q >> 1;
          tx_bit_q  <= BIT_FIRST;
          tx_st_q   <= ST_DATA;
        end
        ST_DATA: if (tx_tick) begin  // RULE7
          if (tx_bit_q == BIT_LAST) begin
            tx_line_q <= LINE_IDLE;  // RULE15
            tx_st_q   <= ST_STOP;
          end else begin
            tx_line_q <= tx_sh_q[0];  // RULE15
            tx_sh_q   <= tx_sh_q >> 1;
            tx_bit_q  <= tx_bit_q + 3'h1;
          end
        end
        default: if (tx_tick) tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // receiver from the target, sampled mid-bit
  // ------------------------------------------------------------------
  assign rx_tick = (rx_cnt_q == div_q - DIV_ONE);
  assign rx_half = (rx_cnt_q == (div_q >> 1));
  assign rx_done = (rx_st_q == ST_STOP) && rx_tick && (line_s == LINE_IDLE);

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rx_st_q  <= ST_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= BIT_FIRST;
      rx_sh_q  <= BYTE_ZERO;
    end else begin
      rx_cnt_q <= rx_cnt_q + DIV_ONE;
      case (rx_st_q)
        ST_IDLE: begin
          rx_cnt_q <= '0;
          if (en_s && line_s == LINE_STRT) rx_st_q <= ST_START;  // RULE12
        end
        ST_START: if (rx_half) begin
          rx_cnt_q <= '0;
          rx_bit_q <= BIT_FIRST;
          rx_st_q  <= (line_s == LINE_STRT) ? ST_DATA : ST_IDLE;  // RULE15
        end
        ST_DATA: if (rx_tick) begin
          rx_cnt_q <= '0;
          rx_sh_q  <= {line_s, rx_sh_q[7:1]};  // RULE15
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == BIT_LAST) rx_st_q <= ST_STOP;
        end
        default: if (rx_tick) rx_st_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // receive buffer toward the host; a byte arriving full is dropped
  // ------------------------------------------------------------------
  assign out_valid = (cnt_q != '0);
  assign pop       = out_valid && out_ready;
  assign push      = rx_done && (cnt_q != CNT_FULL);

  always_ff @(posedge mclk_i) begin
    if (push) mem_q[wr_q] <= rx_sh_q;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // clear-to-send: dropped one slot early so a character in flight fits
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      link.cts_drv <= 1'b0;
      link.cts_oe  <= 1'b0;
    end else begin
      link.cts_drv <= (cnt_q < CNT_ROOM);  // RULE4
      link.cts_oe  <= hs_drive;  // RULE4 RULE5
    end
  end

endmodule // vsb_bridge

// File: tb/vsb_link_props.sv
// Purpose: checker on the link carrier between bridge and target ends
// Assumes: every frame runs at DIV cycles a bit
// Notes:   line 0 is tgt_rx, line 1 is tgt_tx
`timescale 1ns/1ns
module vsb_link_props #(
  parameter int DIV = 271
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic tgt_tx,
  input wire logic tgt_rx,
  input wire logic cts_drv,
  input wire logic cts_oe,
  input wire logic rts,
  input wire logic en,
  input wire logic cts
);
  // ------------------------------------------------------------------
  // frame trackers
  // ------------------------------------------------------------------
  logic [1:0] ln;
  logic [1:0] prev_q;
  logic [1:0] busy_q;
  int         cnt_q [2];
  logic [1:0] start;

  // a start is a fall seen outside a frame
  assign ln    = {tgt_tx, tgt_rx};
  assign start = ~busy_q & prev_q & ~ln;

  // last line level, mark after reset
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      prev_q <= 2'b11;
    end else begin
      prev_q <= ln;
    end
  end

  // position in frame, cleared on the last stop sample
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (!rst_b_i || cnt_q[i] == 10 * DIV - 1) begin
        busy_q[i] <= 1'b0;
        cnt_q[i]  <= 0;
      end else if (start[i]) begin
        busy_q[i] <= 1'b1;
        cnt_q[i]  <= 1;
      end else if (busy_q[i]) begin
        cnt_q[i] <= cnt_q[i] + 1;
      end
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  AST_RST_IDLE: assert property ($rose(rst_b_i) |-> ln == 2'b11 && !cts_oe && !rts && !en)
    else $error("link not quiet after reset");
  AST_RX_START: assert property (busy_q[0] && cnt_q[0] < DIV |-> !tgt_rx)
    else $error("start bit short on target rx");
  AST_RX_STOP: assert property (busy_q[0] && cnt_q[0] >= 9 * DIV |-> tgt_rx)
    else $error("stop bit wrong on target rx");
  AST_RX_HOLD: assert property (busy_q[0] && cnt_q[0] % DIV != 0 |-> $stable(tgt_rx))
    else $error("target rx moved inside a bit");
  AST_TX_START: assert property (busy_q[1] && cnt_q[1] < DIV |-> !tgt_tx)
    else $error("start bit short on target tx");
  AST_TX_STOP: assert property (busy_q[1] && cnt_q[1] >= 9 * DIV |-> tgt_tx)
    else $error("stop bit wrong on target tx");
  AST_TX_HOLD: assert property (busy_q[1] && cnt_q[1] % DIV != 0 |-> $stable(tgt_tx))
    else $error("target tx moved inside a bit");
  AST_RX_EN: assert property (start[0] |-> $past(en, 3))
    else $error("frame sent while enable low");
  AST_PULLUP: assert property (!cts_oe |-> cts)
    else $error("undriven clear-to-send not high");

  // main scenarios reached
  COV_RX_FRAME: cover property (start[0]);
  COV_TX_FRAME: cover property (start[1]);
  COV_CTS_FULL: cover property (cts_oe && !cts_drv);
  COV_RTS_DROP: cover property (busy_q[0] && $fell(rts));
endmodule // vsb_link_props

// File: tb/tb.sv
// Purpose: self-checking bench joining bridge and target ends
// Assumes: link frames only after the 921600 setting, 271 cycles a bit
// Notes:   buffer depth cut to 4 so clear-to-send drops after three bytes
`timescale 1ns/1ns
module tb;
  import vsb_pkg::*;
  // ------------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------------
  logic        mclk_i  = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cfg_wr  = 1'b0;
  logic [19:0] baud    = BAUD_DEF;
  vsb_hs_type  hs      = HS_DISABLED;
  logic        sock    = 1'b0;
  logic [1:0]  h_vld   = 2'b00;
  logic [7:0]  h_dat   = 8'h00;
  logic [1:0]  r_rdy   = 2'b00;
  logic        hw_hs   = 1'b0;
  logic        en      = 1'b0;
  logic        t_rts   = 1'b0;
  logic        t_vld   = 1'b0;
  logic [7:0]  t_dat   = 8'h00;
  wire  [1:0]  h_rdy;
  wire  [1:0]  r_vld;
  wire  [7:0]  r_dat [2];
  wire  [15:0] div;
  vsb_hs_type  hs_o;
  wire         t_rdy;
  wire         t_rv;
  wire  [7:0]  t_rx;
  int          failures = 0;
  int          compares = 0;

  // 250 MHz clock
  always #2 mclk_i = ~mclk_i;

  // ------------------------------------------------------------------
  // both ends and the checker
  // ------------------------------------------------------------------
  vsb_link_if link ();
  vsb_bridge #(.RX_DEPTH(4)) u_vsb_bridge (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(link), .cfg_wr_i(cfg_wr),
    .cfg_baud_i(baud), .cfg_hs_i(hs), .cfg_div_o(div), .cfg_hs_o(hs_o),
    .sock_conn_i(sock), .usb_tx_valid_i(h_vld[0]), .usb_tx_data_i(h_dat),
    .usb_tx_ready_o(h_rdy[0]), .sock_tx_valid_i(h_vld[1]), .sock_tx_data_i(h_dat),
    .sock_tx_ready_o(h_rdy[1]), .usb_rx_valid_o(r_vld[0]), .usb_rx_data_o(r_dat[0]),
    .usb_rx_ready_i(r_rdy[0]), .sock_rx_valid_o(r_vld[1]), .sock_rx_data_o(r_dat[1]),
    .sock_rx_ready_i(r_rdy[1]));
  vsb_target u_vsb_target (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(link), .cfg_div_i(div),
    .hw_hs_i(hw_hs), .en_i(en), .rx_ready_i(t_rts), .tx_valid_i(t_vld),
    .tx_data_i(t_dat), .tx_ready_o(t_rdy), .rx_valid_o(t_rv), .rx_data_o(t_rx));
  vsb_link_props #(.DIV(271)) u_vsb_link_props (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .tgt_tx(link.tgt_tx), .tgt_rx(link.tgt_rx),
    .cts_drv(link.cts_drv), .cts_oe(link.cts_oe), .rts(link.rts), .en(link.en),
    .cts(link.cts));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // waits two settle cycles so the write lands before anything is looked at
  task automatic cfg(input logic [19:0] b, input vsb_hs_type h);
    @(negedge mclk_i);
    cfg_wr = 1'b1;
    baud   = b;
    hs     = h;
    @(negedge mclk_i);
    cfg_wr = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask

  // p selects usb (0) or socket (1); ready is read settled at the falling
  // edge, so the rising edge after the last look is the one that takes it
  task automatic host_tx(input int p, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk_i);
    h_vld[p] = 1'b1;
    h_dat    = d;
    while (h_rdy[p] !== 1'b1 && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    @(negedge mclk_i);
    h_vld[p] = 1'b0;
  endtask

  task automatic tgt_send(input logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk_i);
    t_vld = 1'b1;
    t_dat = d;
    while (t_rdy !== 1'b1 && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    @(negedge mclk_i);
    t_vld = 1'b0;
  endtask

  task automatic tgt_get(input logic [7:0] d);
    int n;
    n = 0;
    while (t_rv !== 1'b1 && n < 6000) begin
      @(negedge mclk_i);
      n++;
    end
    chk(16'({t_rv, t_rx}), 16'({1'b1, d}), "target byte");
  endtask

  // selected path shows the byte, the other stays quiet
  task automatic host_get(input int p, input logic [7:0] d);
    int n;
    n = 0;
    while (r_vld[p] !== 1'b1 && n < 6000) begin
      @(negedge mclk_i);
      n++;
    end
    chk(16'({r_vld[p], r_vld[1-p], r_dat[p]}), 16'({2'b10, d}), "host byte");
    r_rdy[p] = 1'b1;
    @(negedge mclk_i);
    r_rdy[p] = 1'b0;
  endtask

  // bit centres of one frame on target rx
  task automatic wire_chk(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    repeat (135) @(posedge mclk_i);
    for (int i = 0; i < 10; i++) begin
      chk(16'(link.tgt_rx), 16'(f[i]), "frame bit");
      repeat (271) @(posedge mclk_i);
    end
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_cfg();
    chk(div, DIV_DEF, "default bit time");
    chk(16'(hs_o), 16'(HS_DISABLED), "default handshake");
    chk(16'(link.cts_oe), 16'h0000, "cts driven at reset");
    cfg(BAUD_MIN, HS_RTS);
    chk(div, 16'h65B9, "slowest bit time");
    chk(16'({link.cts_oe, link.cts}), 16'h0003, "cts asserted");
    cfg(20'hF_FFFF, HS_RTS);
    chk(div, 16'h010F, "fast clamp");
    en    = 1'b1;
    repeat (8) @(negedge mclk_i);
    $display("test config done");
  endtask

  // rts low is ignored in this setting
  task automatic t_rts_mode();
    chk(16'(h_rdy[0]), 16'h0001, "rts not ignored");
    fork
      begin
        host_tx(0, 8'hA5);
        wire_chk(8'hA5);
      end
      tgt_get(8'hA5);
    join
    $display("test rts mode done");
  endtask

  // drop rts in mid-frame: the frame finishes, the next waits
  task automatic t_cts_mode();
    cfg(BAUD_MAX, HS_CTS);
    chk(16'(link.cts_oe), 16'h0000, "cts driven in cts mode");
    chk(16'(h_rdy[0]), 16'h0000, "sent while rts low");
    t_rts = 1'b1;
    host_tx(0, 8'h3C);
    repeat (400) @(negedge mclk_i);
    t_rts = 1'b0;
    tgt_get(8'h3C);
    chk(16'(h_rdy[0]), 16'h0000, "ready while rts low");
    t_rts = 1'b1;
    $display("test cts mode done");
  endtask

  task automatic t_sock();
    sock = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk(16'(h_rdy[0]), 16'h0000, "usb open with socket");
    host_tx(1, 8'h96);
    tgt_get(8'h96);
    tgt_send(8'h5A);
    host_get(1, 8'h5A);
    sock = 1'b0;
    $display("test socket path done");
  endtask

  // fill the buffer: cts drops and the target holds off
  task automatic t_full();
    int n;
    n = 0;
    cfg(BAUD_MAX, HS_RTSCTS);
    hw_hs = 1'b1;
    tgt_send(8'h11);
    tgt_send(8'h22);
    tgt_send(8'h33);
    while (link.cts !== 1'b0 && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    chk(16'(link.cts), 16'h0000, "cts not dropped");
    // wait past the stop bit so only clear-to-send can hold the target off
    repeat (200) @(negedge mclk_i);
    chk(16'(t_rdy), 16'h0000, "target sends into full");
    host_get(0, 8'h11);
    host_get(0, 8'h22);
    host_get(0, 8'h33);
    repeat (4) @(negedge mclk_i);
    chk(16'(link.cts), 16'h0001, "cts not back");
    hw_hs = 1'b0;
    $display("test buffer full done");
  endtask

  // target end still sends; the bridge must not pass the byte on
  task automatic t_enable();
    int n;
    n = 0;
    en = 1'b0;
    repeat (6) @(negedge mclk_i);
    chk(16'(h_rdy[0]), 16'h0000, "ready with enable low");
    tgt_send(8'hC3);
    while (r_vld[0] !== 1'b1 && n < 3000) begin
      @(negedge mclk_i);
      n++;
    end
    chk(16'(r_vld[0]), 16'h0000, "byte passed with enable low");
    $display("test enable done");
  endtask

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(negedge mclk_i);
    rst_b_i = 1'b1;
    @(negedge mclk_i);
    t_cfg();
    t_rts_mode();
    t_cts_mode();
    t_sock();
    t_full();
    t_enable();
    test_done();
  end

  // about three times the expected run
  initial begin
    #250000;
    failures++;
    test_done();
  end
endmodule // tb
